// [shared/frame_if.sv]
interface frame_if;
	logic done;
	logic overflow;
	logic busy;
	logic [4:0] len;
	logic [23:0] bits;

	modport source(output done, overflow, busy, len, bits);
	modport sink(input done, overflow, busy, len, bits);
endinterface

// [shared/synth_cfg_pkg.sv]
package synth_cfg_pkg;

	// ------------------------------------------------------------
	// Serial command layout
	// ------------------------------------------------------------
	localparam int MAX_BITS = 24;
	localparam logic [4:0] LEN_SHORT = 5'h10;
	localparam logic [4:0] LEN_LONG = 5'h18;
	localparam logic [1:0] ADDR_ALIGN = 2'h1;
	localparam logic [1:0] ADDR_MODE = 2'h2;
	localparam logic [1:0] ADDR_PUMP = 2'h3;
	// First control bit held by each register
	localparam int BASE_ALIGN = 0;
	localparam int BASE_MODE = 28;
	localparam int BASE_PUMP = 66;

	// ------------------------------------------------------------
	// Field positions in the control bit space
	// ------------------------------------------------------------
	localparam int PUMP_SEL_LSB = 70;
	localparam int REF_OFF_BIT = 69;
	localparam int AM_MODE_BIT = 34;
	localparam int GAIN1_LSB = 36;
	localparam int OFFS1_LSB = 44;
	localparam int GAIN2_LSB = 0;
	localparam int OFFS2_LSB = 8;
	localparam int GAIN_W = 8;
	localparam int OFFS_W = 6;

	// ------------------------------------------------------------
	// Analog settings as codes
	// ------------------------------------------------------------
	localparam logic [10:0] PUMP_UA_0 = 11'h019;
	localparam logic [10:0] PUMP_UA_1 = 11'h064;
	localparam logic [10:0] PUMP_UA_2 = 11'h1f4;
	localparam logic [10:0] PUMP_UA_3 = 11'h7d0;
	localparam logic [11:0] INT_REF_MV = 12'hbb8;

	// ------------------------------------------------------------
	// APB map and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ALIGN2 = 8'h08;
	localparam logic [7:0] OFS_ALIGN1 = 8'h0c;
	localparam logic [7:0] OFS_PUMP = 8'h10;
	localparam logic RST_RX_ENABLE = 1'h1;
	localparam logic [1:0] RST_PUMP_SEL = 2'h0;
	localparam logic RST_REF_OFF = 1'h0;
	localparam logic RST_AM = 1'h0;
	localparam logic [7:0] RST_GAIN = 8'h00;
	localparam logic [5:0] RST_OFFS = 6'h00;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_SHIFT = 2'b10
	} rx_state_type;

endpackage

// [sim/host_bus_model.sv]
module host_bus_model
(
	// Three-wire bus pins
	output logic busEnable,
	output logic busClock,
	output logic busData
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		busEnable = 1'b0;
		busClock = 1'b0;
		busData = 1'b0;
	end
	// Sends len edges, word bit 0 first, wrapping past 24
	task automatic send(input int len, input logic [23:0] word);
		busEnable = 1'b1;
		for (int i = 0; i < len; i++) begin
			busData = word[i % 24];
			#62.5 busClock = 1'b1;
			#62.5 busClock = 1'b0;
		end
		#40 busEnable = 1'b0;
		busData = ~busData;
		#100;
	endtask
endmodule

// [sim/synth_cfg_properties.sv]
module synth_cfg_properties
	import synth_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Pins and bus
	input wire logic busEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [11:0] loopTuningMv,
	// Settings
	input wire logic [1:0] pumpCurrentSelect,
	input wire logic [10:0] pumpCurrentUa,
	input wire logic refBufferOff,
	input wire logic refBufferOut,
	input wire logic amMode,
	input wire logic [7:0] firstGain,
	input wire logic [5:0] firstOffset,
	input wire logic [7:0] secondGain,
	input wire logic [5:0] secondOffset,
	input wire logic refInternal,
	input wire logic [11:0] converterRefMv
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [10:0] UA_TAB [4] = '{PUMP_UA_0, PUMP_UA_1,
		PUMP_UA_2, PUMP_UA_3};
	logic rdAcc;
	logic [31:0] flds;
	assign rdAcc = psel && penable && !pwrite;
	assign flds = {pumpCurrentSelect, refBufferOff, amMode, firstGain,
		firstOffset, secondGain, secondOffset};
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);

	pump_ua_a: assert property (
		$stable(pumpCurrentSelect) && $past(ce) && !$past(srst)
		|-> pumpCurrentUa == UA_TAB[pumpCurrentSelect])
		else $error("pump current mismatch");
	ref_out_a: assert property (
		refBufferOut == !refBufferOff) else $error("buffer output wrong");
	ref_src_a: assert property (
		refInternal == amMode) else $error("reference source wrong");
	conv_ref_a: assert property (
		$stable(amMode) && $past(ce) && !$past(srst) |-> converterRefMv
		== (amMode ? INT_REF_MV : $past(loopTuningMv)))
		else $error("converter reference wrong");
	hold_busy_a: assert property (
		busEnable [*8] |=> $stable(flds)) else $error("change in command");
	upd_end_a: assert property (
		!$stable(flds) && !$past(srst) |-> !$past(busEnable, 2))
		else $error("change before enable fell");
	align2_rd_a: assert property (
		rdAcc && paddr == OFS_ALIGN2 && $stable(flds)
		|-> prdata[13:0] == {secondOffset, secondGain})
		else $error("second converter readback wrong");
	align1_rd_a: assert property (
		rdAcc && paddr == OFS_ALIGN1 && $stable(flds)
		|-> prdata[16:0] == {amMode, 2'h0, firstOffset, firstGain})
		else $error("first converter readback wrong");
	pump_rd_a: assert property (
		rdAcc && paddr == OFS_PUMP && $stable(flds) && $stable(pumpCurrentUa)
		|-> prdata[13:0] == {pumpCurrentUa, refBufferOff, pumpCurrentSelect})
		else $error("pump readback wrong");

	cover property ($rose(amMode));
	cover property (pumpCurrentSelect == 2'h3);
	cover property (rdAcc && pslverr);
endmodule

// [sim/testbench.sv]
module testbench
	import synth_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic ce = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, busEnable, busClock, busData, err;
	logic refBufferOff, refBufferOut, amMode, refInternal;
	logic [1:0] pumpCurrentSelect;
	logic [10:0] pumpCurrentUa;
	logic [7:0] firstGain, secondGain;
	logic [5:0] firstOffset, secondOffset;
	logic [11:0] converterRefMv;
	int miscompares = 0;
	int check_count = 0;
	localparam logic [11:0] TUNE = 12'h4d2;
	localparam logic [10:0] UA [4] = '{PUMP_UA_0, PUMP_UA_1, PUMP_UA_2,
		PUMP_UA_3};
	localparam logic [31:0] KEEP = {2'b11, 1'b1, 1'b0, 8'hff, 6'h3f,
		8'ha5, 6'h2b};
	int badLen [5] = '{24, 16, 16, 20, 25};
	logic [23:0] badWord [5] = '{24'h400000, 24'h008000, 24'h00c000,
		24'h0fffff, 24'hc00000};

	always #5 clk = ~clk;
	host_bus_model hostU (.*);
	synth_tuner_config_decode dut_u (.ce(ce), .loopTuningMv(TUNE), .*);

	// ------
	// Tasks
	// ------
	function automatic logic [31:0] fields();
		return {pumpCurrentSelect, refBufferOff, amMode, firstGain,
			firstOffset, secondGain, secondOffset};
	endfunction
	task automatic close_out();
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic frame(input int len, input logic [23:0] w);
		@(negedge clk);
		hostU.send(len, w);
		@(negedge clk);
	endtask

	// ------
	// Tests
	// ------
	initial begin
		repeat (2) @(posedge clk);
		#1;
		check(fields(), 32'h0);
		check({8'h0, pumpCurrentUa, refBufferOut, converterRefMv},
			{8'h0, PUMP_UA_0, 1'b1, 12'h000});
		@(posedge clk);
		srst <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0);
		check(rd, 32'h1);
		for (int k = 0; k < 4; k++) begin
			frame(24, {2'b11, 16'h0, k[1:0], k[0], 3'h0});
			check({19'h0, pumpCurrentSelect, pumpCurrentUa},
				{19'h0, k[1:0], UA[k]});
			check({30'h0, refBufferOff, refBufferOut},
				{30'h0, k[0], ~k[0]});
		end
		apb(1'b0, OFS_PUMP, 32'h0);
		check(rd, {18'h0, PUMP_UA_3, 1'b1, 2'b11});
		frame(16, {8'h00, 2'b01, 6'h2b, 8'ha5});
		apb(1'b0, OFS_ALIGN2, 32'h0);
		check(rd, {18'h0, 6'h2b, 8'ha5});
		frame(24, {2'b10, 6'h11, 8'h3c, 2'b01, 6'h3f});
		check({4'h0, amMode, refInternal, firstGain, firstOffset,
			converterRefMv},
			{6'h03, 8'h3c, 6'h11, INT_REF_MV});
		check(fields() & 32'h3fff, {18'h0, 8'ha5, 6'h2b});
		frame(24, {2'b10, 6'h3f, 8'hff, 8'h00});
		check({4'h0, amMode, refInternal, firstGain, firstOffset,
			converterRefMv}, {6'h00, 8'hff, 6'h3f, TUNE});
		apb(1'b0, OFS_ALIGN1, 32'h0);
		check(rd, {18'h0, 6'h3f, 8'hff});
		apb(1'b1, OFS_STATUS, 32'h0);
		for (int j = 0; j < 5; j++) begin
			frame(badLen[j], badWord[j]);
			check(fields(), KEEP);
		end
		apb(1'b1, OFS_CTRL, 32'h0);
		frame(24, 24'hc00000);
		check(fields(), KEEP);
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd, {11'h0, LEN_LONG, 8'h06, 8'h00});
		apb(1'b0, 8'h20, 32'h0);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
		// Frozen clock enable: no command lands, no bus answer
		@(posedge clk);
		ce <= 1'b0;
		frame(24, 24'hc00000);
		check({31'h0, pready}, 32'h0);
		@(posedge clk);
		ce <= 1'b1;
		@(negedge clk);
		check(fields(), KEEP);
		// Reset in mid-run brings every field back
		apb(1'b1, OFS_CTRL, 32'h0);
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		check(fields(), 32'h0);
		check({31'h0, refBufferOut}, 32'h1);
		apb(1'b0, OFS_CTRL, 32'h0);
		check(rd, 32'h1);
		close_out();
	end
endmodule

bind synth_tuner_config_decode synth_cfg_properties chkU (.*);

// [src/serial_frame_rx.sv]
module serial_frame_rx
	import synth_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Bus pins
	input wire logic busEnable,
	input wire logic busClock,
	input wire logic busData,
	// Completed commands
	frame_if.source frm
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic [2:0] prev_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
			prev_q <= 3'h0;
		end else if (ce) begin
			meta_q <= {busData, busClock, busEnable};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	logic enRise, enFall, clkRise;
	assign enRise = sync_q[0] & ~prev_q[0];
	assign enFall = ~sync_q[0] & prev_q[0];
	assign clkRise = sync_q[1] & ~prev_q[1];

	// ------------------------------------------------------------
	// Shift state
	// ------------------------------------------------------------
	rx_state_type state_q, state_d;
	logic [4:0] count_q, count_d;
	logic [23:0] bits_q, bits_d;
	logic ovf_q, ovf_d;
	logic done_q, done_d;
	logic [4:0] len_q, len_d;
	logic [23:0] out_q, out_d;
	logic outOvf_q, outOvf_d;

	always_comb begin
		state_d = state_q;
		count_d = count_q;
		bits_d = bits_q;
		ovf_d = ovf_q;
		done_d = 1'b0;
		len_d = len_q;
		out_d = out_q;
		outOvf_d = outOvf_q;
		unique case (state_q)
			RX_IDLE: begin
				if (enRise) begin
					state_d = RX_SHIFT;
					count_d = 5'h0;
					bits_d = 24'h0;
					ovf_d = 1'b0;
				end
			end
			RX_SHIFT: begin
				if (enFall) begin
					state_d = RX_IDLE;
					done_d = 1'b1;
					len_d = count_q;
					out_d = bits_q;
					outOvf_d = ovf_q;
				end else if (clkRise && sync_q[0]) begin
					if (count_q == 5'(MAX_BITS)) begin
						ovf_d = 1'b1;
					end else begin
						bits_d[count_q] = sync_q[2];
						count_d = count_q + 5'h1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= RX_IDLE;
			count_q <= 5'h0;
			bits_q <= 24'h0;
			ovf_q <= 1'b0;
			done_q <= 1'b0;
			len_q <= 5'h0;
			out_q <= 24'h0;
			outOvf_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			count_q <= count_d;
			bits_q <= bits_d;
			ovf_q <= ovf_d;
			done_q <= done_d;
			len_q <= len_d;
			out_q <= out_d;
			outOvf_q <= outOvf_d;
		end
	end

	assign frm.done = done_q;
	assign frm.len = len_q;
	assign frm.bits = out_q;
	assign frm.overflow = outOvf_q;
	assign frm.busy = (state_q == RX_SHIFT);

endmodule

// [src/synth_tuner_config_decode.sv]
// Our own choices: the register addresses and the APB register port.
module synth_tuner_config_decode
	import synth_cfg_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Three-wire bus pins
	input wire logic busEnable,
	input wire logic busClock,
	input wire logic busData,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Loop tuning voltage in mV
	input wire logic [11:0] loopTuningMv,
	// Decoded settings
	output logic [1:0] pumpCurrentSelect,
	output logic [10:0] pumpCurrentUa,
	output logic refBufferOff,
	output logic refBufferOut,
	output logic amMode,
	output logic [7:0] firstGain,
	output logic [5:0] firstOffset,
	output logic [7:0] secondGain,
	output logic [5:0] secondOffset,
	output logic refInternal,
	output logic [11:0] converterRefMv
);

	// ------------------------------------------------------------
	// Serial receiver
	// ------------------------------------------------------------
	frame_if frm ();

	serial_frame_rx rx (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.busEnable(busEnable),
		.busClock(busClock),
		.busData(busData),
		.frm(frm)
	);

	// ------------------------------------------------------------
	// Command match
	// ------------------------------------------------------------
	logic rxEnable_q, rxEnable_d;
	logic [1:0] cmdAddr;
	logic [21:0] cmdData;
	logic hitAlign, hitMode, hitPump, cmdValid;

	always_comb begin
		cmdAddr = 2'h0;
		cmdData = 22'h0;
		if (frm.len == LEN_SHORT) begin
			cmdAddr = frm.bits[15:14];
			cmdData = {8'h0, frm.bits[13:0]};
		end else if (frm.len == LEN_LONG) begin
			cmdAddr = frm.bits[23:22];
			cmdData = frm.bits[21:0];
		end
	end

	// A command counts only when complete and enabled by software
	assign cmdValid = frm.done & ~frm.overflow & rxEnable_q;
	assign hitAlign = cmdValid & (frm.len == LEN_SHORT)
		& (cmdAddr == ADDR_ALIGN);
	assign hitMode = cmdValid & (frm.len == LEN_LONG)
		& (cmdAddr == ADDR_MODE);
	assign hitPump = cmdValid & (frm.len == LEN_LONG)
		& (cmdAddr == ADDR_PUMP);

	// ------------------------------------------------------------
	// Decoded fields
	// ------------------------------------------------------------
	logic [1:0] pump_q, pump_d;
	logic refOff_q, refOff_d;
	logic am_q, am_d;

	always_comb begin
		pump_d = pump_q;
		refOff_d = refOff_q;
		am_d = am_q;
		// Mismatched or aborted commands leave all fields alone
		if (hitPump) begin
			pump_d = cmdData[PUMP_SEL_LSB - BASE_PUMP +: 2];
			refOff_d = cmdData[REF_OFF_BIT - BASE_PUMP];
		end
		if (hitMode) begin
			am_d = cmdData[AM_MODE_BIT - BASE_MODE];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pump_q <= RST_PUMP_SEL;
			refOff_q <= RST_REF_OFF;
			am_q <= RST_AM;
		end else if (ce) begin
			pump_q <= pump_d;
			refOff_q <= refOff_d;
			am_q <= am_d;
		end
	end

	// ------------------------------------------------------------
	// Alignment converter codes, one slice per converter
	// ------------------------------------------------------------
	// Slice 0 serves the first converter, slice 1 the second
	logic [1:0] convHit;
	logic [7:0] gain_q [2];
	logic [7:0] gain_d [2];
	logic [5:0] offs_q [2];
	logic [5:0] offs_d [2];

	assign convHit = {hitAlign, hitMode};

	for (genvar c = 0; c < 2; c++) begin : conv_g
		// Where each code sits in the matching command's data
		localparam int GAIN_AT = (c == 0) ? GAIN1_LSB - BASE_MODE
			: GAIN2_LSB - BASE_ALIGN;
		localparam int OFFS_AT = (c == 0) ? OFFS1_LSB - BASE_MODE
			: OFFS2_LSB - BASE_ALIGN;

		always_comb begin
			gain_d[c] = gain_q[c];
			offs_d[c] = offs_q[c];
			if (convHit[c]) begin
				gain_d[c] = cmdData[GAIN_AT +: GAIN_W];
				offs_d[c] = cmdData[OFFS_AT +: OFFS_W];
			end
		end

		always_ff @(posedge clk) begin
			if (srst) begin
				gain_q[c] <= RST_GAIN;
				offs_q[c] <= RST_OFFS;
			end else if (ce) begin
				gain_q[c] <= gain_d[c];
				offs_q[c] <= offs_d[c];
			end
		end
	end

	// ------------------------------------------------------------
	// Analog-facing outputs
	// ------------------------------------------------------------
	logic [10:0] pumpUa_q, pumpUa_d;
	logic [11:0] refMv_q, refMv_d;
	logic refOut_q, refOut_d;
	logic refInt_q, refInt_d;

	always_comb begin
		unique case (pump_q)
			2'h0: pumpUa_d = PUMP_UA_0;
			2'h1: pumpUa_d = PUMP_UA_1;
			2'h2: pumpUa_d = PUMP_UA_2;
			2'h3: pumpUa_d = PUMP_UA_3;
		endcase
		// Only the reference source changes with the mode
		refMv_d = am_q ? INT_REF_MV : loopTuningMv;
		// Flopped copies that move in the same cycle as their fields
		refOut_d = ~refOff_d;
		refInt_d = am_d;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pumpUa_q <= PUMP_UA_0;
			refMv_q <= 12'h0;
			refOut_q <= ~RST_REF_OFF;
			refInt_q <= RST_AM;
		end else if (ce) begin
			pumpUa_q <= pumpUa_d;
			refMv_q <= refMv_d;
			refOut_q <= refOut_d;
			refInt_q <= refInt_d;
		end
	end

	assign pumpCurrentSelect = pump_q;
	assign pumpCurrentUa = pumpUa_q;
	assign refBufferOff = refOff_q;
	assign refBufferOut = refOut_q;
	assign amMode = am_q;
	assign refInternal = refInt_q;
	assign converterRefMv = refMv_q;
	// Codes step linearly: gain 0 lowest, offset 0 most positive
	assign firstGain = gain_q[0];
	assign secondGain = gain_q[1];
	assign firstOffset = offs_q[0];
	assign secondOffset = offs_q[1];

	// ------------------------------------------------------------
	// Command statistics
	// ------------------------------------------------------------
	logic [7:0] okCount_q, okCount_d;
	logic [7:0] badCount_q, badCount_d;
	logic [4:0] lastLen_q, lastLen_d;
	logic hit, statClear;

	assign hit = hitAlign | hitMode | hitPump;

	// A clear in the same cycle applies first; the command then counts from zero
	always_comb begin
		okCount_d = okCount_q;
		badCount_d = badCount_q;
		lastLen_d = lastLen_q;
		if (statClear) begin
			okCount_d = 8'h0;
			badCount_d = 8'h0;
		end
		if (frm.done) begin
			lastLen_d = frm.len;
			if (hit) begin
				okCount_d = okCount_d + 8'h1;
			end else begin
				badCount_d = badCount_d + 8'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			okCount_q <= 8'h0;
			badCount_q <= 8'h0;
			lastLen_q <= 5'h0;
		end else if (ce) begin
			okCount_q <= okCount_d;
			badCount_q <= badCount_d;
			lastLen_q <= lastLen_d;
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	logic setup, access, mapped;
	logic [31:0] rdMux;

	assign setup = psel & ~penable;
	assign access = psel & penable & ce;
	assign statClear = access & pwrite & (paddr == OFS_STATUS);

	always_comb begin
		mapped = 1'b1;
		rdMux = 32'h0;
		unique case (paddr)
			OFS_CTRL: rdMux = {31'h0, rxEnable_q};
			OFS_STATUS: rdMux = {10'h0, frm.busy, lastLen_q,
				badCount_q, okCount_q};
			OFS_ALIGN2: rdMux = {18'h0, offs_q[1], gain_q[1]};
			OFS_ALIGN1: rdMux = {15'h0, am_q, 2'h0,
				offs_q[0], gain_q[0]};
			OFS_PUMP: rdMux = {18'h0, pumpUa_q, refOff_q, pump_q};
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		rdata_d = rdata_q;
		err_d = err_q;
		rxEnable_d = rxEnable_q;
		if (setup) begin
			rdata_d = pwrite ? 32'h0 : rdMux;
			err_d = ~mapped;
		end
		if (access && pwrite && paddr == OFS_CTRL) begin
			rxEnable_d = pwdata[0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 32'h0;
			err_q <= 1'b0;
			rxEnable_q <= RST_RX_ENABLE;
		end else if (ce) begin
			rdata_q <= rdata_d;
			err_q <= err_d;
			rxEnable_q <= rxEnable_d;
		end
	end

	// Zero wait states; held off while the clock enable is low
	assign pready = ce;
	assign prdata = rdata_q;
	assign pslverr = err_q & psel & penable;

endmodule
